// File: rtl/charger_event_flag_mask_bank.sv
// event flag registers and first interrupt mask register of the charger
`timescale 1ns/1ps
`default_nettype none
`include "charger_event_map.svh"

module charger_event_flag_mask_bank
  import charger_event_pkg::*;
(
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  input  wire logic [7:0]               regAddr,
  input  wire logic                     regWrEn,
  input  wire charger_event_pkg::byte_t regWrData,
  input  wire logic                     regRdEn,
  output var  charger_event_pkg::byte_t regRdData,
  input  wire logic                     regResetCmd,
  input  wire charger_event_pkg::byte_t busCurrentStatus,
  input  wire charger_event_pkg::byte_t inputStatus,
  input  wire charger_event_pkg::byte_t thermalStatus,
  input  wire charger_event_pkg::byte_t converterStatus,
  input  wire logic                     adcOneShot,
  input  wire charger_event_pkg::byte_t batteryFlags,
  input  wire logic [31:0]              laterMasks,
  output var  logic                     irqOut
);
  import charger_event_pkg::*;

  // ----------------------------------------------------------
  // reset release
  // ----------------------------------------------------------
  logic [1:0] rstPipe_q;
  logic       rstN;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstPipe_q <= 2'b00;
    end else begin
      rstPipe_q <= {rstPipe_q[0], 1'b1};
    end
  end

  assign rstN = rstPipe_q[1];

  // ----------------------------------------------------------
  // address decode
  // ----------------------------------------------------------
  function automatic reg_sel_t decodeAddr(input byte_t a);
    reg_sel_t s;
    s = '0;
    unique case (a)
      `OFF_BUS_FLAGS:     s[0] = 1'b1;
      `OFF_INPUT_FLAGS:   s[1] = 1'b1;
      `OFF_THERMAL_FLAGS: s[2] = 1'b1;
      `OFF_CONV_FLAGS:    s[3] = 1'b1;
      `OFF_BATTERY_MASKS: s[SelMask] = 1'b1;
      default:            s = '0;
    endcase
    return s;
  endfunction

  reg_sel_t rdSel;
  reg_sel_t wrSel;

  assign rdSel = regRdEn ? decodeAddr(regAddr) : '0;
  assign wrSel = regWrEn ? decodeAddr(regAddr) : '0;

  // ----------------------------------------------------------
  // status change detection
  // ----------------------------------------------------------
  localparam byte_t ValidMask [NumFlagRegs] = '{
    `VALID_BUS_FLAGS,
    `VALID_INPUT_FLAGS,
    `VALID_THERMAL_FLAGS,
    `VALID_CONV_FLAGS
  };

  localparam byte_t AdcBit = byte_t'(1) << `BIT_ADC_DONE;

  byte_t statusIn     [NumFlagRegs];
  byte_t statusPrev_q [NumFlagRegs];
  byte_t statusPrev_d [NumFlagRegs];
  byte_t setEv        [NumFlagRegs];
  byte_t flag_q       [NumFlagRegs];
  byte_t flag_d       [NumFlagRegs];

  assign statusIn[0] = busCurrentStatus;
  assign statusIn[1] = inputStatus;
  assign statusIn[2] = thermalStatus;
  assign statusIn[3] = converterStatus;

  // the watchdog expiry arrives as a status bit like any other
  // event, so bit 0 of the thermal register needs no special path
  genvar gi;
  generate
    for (gi = 0; gi < NumFlagRegs; gi++) begin : gEvt
      byte_t change;
      assign change = (statusIn[gi] ^ statusPrev_q[gi]) & ValidMask[gi];
      if (gi == 2) begin : gAdc
        // continuous conversion never reports completion
        assign setEv[gi] = adcOneShot ? change : (change & ~AdcBit);
      end else begin : gPlain
        assign setEv[gi] = change;
      end
    end
  endgenerate

  // ----------------------------------------------------------
  // flag registers
  // ----------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NumFlagRegs; i++) begin
      statusPrev_d[i] = statusIn[i];
      // a new event in the read cycle survives the clear
      if (rdSel[i]) begin
        flag_d[i] = setEv[i];
      end else begin
        flag_d[i] = flag_q[i] | setEv[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < NumFlagRegs; i++) begin
        flag_q[i]       <= `RESET_FLAGS;
        statusPrev_q[i] <= `RESET_FLAGS;
      end
    end else begin
      for (int i = 0; i < NumFlagRegs; i++) begin
        flag_q[i]       <= flag_d[i];
        statusPrev_q[i] <= statusPrev_d[i];
      end
    end
  end

  // ----------------------------------------------------------
  // mask register and read port
  // ----------------------------------------------------------
  byte_t mask_q;
  byte_t mask_d;
  byte_t rdData_d;
  logic  irq_d;
  logic [31:0] flagsFlat;

  assign flagsFlat = {flag_q[3], flag_q[2], flag_q[1], flag_q[0]};

  always_comb begin
    mask_d = mask_q;
    if (regResetCmd) begin
      mask_d = `RESET_MASKS;
    end else if (wrSel[SelMask]) begin
      mask_d = regWrData;
    end

    rdData_d = `UNMAPPED_READ;
    for (int i = 0; i < NumFlagRegs; i++) begin
      if (rdSel[i]) begin
        rdData_d = flag_q[i];
      end
    end
    if (rdSel[SelMask]) begin
      rdData_d = mask_q;
    end

    // battery events pair bit for bit with the mask; the later
    // masks are held elsewhere and arrive as a plain vector
    irq_d = (|(batteryFlags & ~mask_q)) | (|(flagsFlat & ~laterMasks));
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      mask_q    <= `RESET_MASKS;
      regRdData <= `UNMAPPED_READ;
      irqOut    <= 1'b0;
    end else begin
      mask_q    <= mask_d;
      regRdData <= rdData_d;
      irqOut    <= irq_d;
    end
  end

  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstN);

  property p_busOcSet;
    (busCurrentStatus[7] != statusPrev_q[0][7]) |=> flag_q[0][7];
  endproperty
  a_busOcSet: assert property (p_busOcSet)
    else $error("bus overcurrent change not flagged");

  property p_fetTwoSet;
    (inputStatus[0] != statusPrev_q[1][0]) |=> flag_q[1][0];
  endproperty
  a_fetTwoSet: assert property (p_fetTwoSet)
    else $error("fet pair two change not flagged");

  property p_dieFaultSet;
    (thermalStatus[2] != statusPrev_q[2][2]) |=> flag_q[2][2];
  endproperty
  a_dieFaultSet: assert property (p_dieFaultSet)
    else $error("die fault change not flagged");

  property p_adcContQuiet;
    (!adcOneShot && !flag_q[2][7]) |=> !flag_q[2][7];
  endproperty
  a_adcContQuiet: assert property (p_adcContQuiet)
    else $error("adc done raised in continuous mode");

  property p_watchdogSet;
    (thermalStatus[0] != statusPrev_q[2][0]) |=> flag_q[2][0];
  endproperty
  a_watchdogSet: assert property (p_watchdogSet)
    else $error("watchdog change not flagged");

  property p_convReserved;
    (flag_q[3] & ~`VALID_CONV_FLAGS) == 8'h00 && (flag_q[0] & 8'h0b) == 8'h00;
  endproperty
  a_convReserved: assert property (p_convReserved)
    else $error("reserved flag bit set");

  property p_readReturns;
    rdSel[1] |=> regRdData == $past(flag_q[1]);
  endproperty
  a_readReturns: assert property (p_readReturns)
    else $error("flag read returned wrong value");

  property p_readClears;
    (rdSel[0] && setEv[0] == 8'h00) |=> flag_q[0] == 8'h00;
  endproperty
  a_readClears: assert property (p_readClears)
    else $error("flag read did not clear");

  property p_maskBlocks;
    (mask_q == 8'hff && laterMasks == 32'hffffffff) |=> !irqOut;
  endproperty
  a_maskBlocks: assert property (p_maskBlocks)
    else $error("masked flag raised interrupt");

  property p_unmaskedIrq;
    (|(batteryFlags & ~mask_q)) |=> irqOut;
  endproperty
  a_unmaskedIrq: assert property (p_unmaskedIrq)
    else $error("unmasked flag gave no interrupt");

  property p_regReset;
    regResetCmd |=> mask_q == 8'h00 ##1 ($past(wrSel[SelMask]) || mask_q == 8'h00);
  endproperty
  a_regReset: assert property (p_regReset)
    else $error("register reset left mask set");

  property p_maskWrite;
    (wrSel[SelMask] && !regResetCmd) |=> mask_q == $past(regWrData);
  endproperty
  a_maskWrite: assert property (p_maskWrite)
    else $error("mask write not stored");

  c_readAfterEvent: cover property (flag_q[0] != 8'h00 ##1 rdSel[0]);
  c_irqRaised: cover property (!irqOut ##1 irqOut);
  c_setDuringRead: cover property (rdSel[2] && setEv[2] != 8'h00);
  c_adcOneShot: cover property (adcOneShot ##1 flag_q[2][7]);

endmodule

`default_nettype wire

// File: shared/charger_event_map.svh
// register offsets, field positions and reset values of the event bank
`ifndef CHARGER_EVENT_MAP_SVH
`define CHARGER_EVENT_MAP_SVH

`define OFF_BATTERY_FLAGS   8'h18
`define OFF_BUS_FLAGS       8'h19
`define OFF_INPUT_FLAGS     8'h1a
`define OFF_THERMAL_FLAGS   8'h1b
`define OFF_CONV_FLAGS      8'h1c
`define OFF_BATTERY_MASKS   8'h1d

`define VALID_BUS_FLAGS     8'hf4
`define VALID_INPUT_FLAGS   8'hff
`define VALID_THERMAL_FLAGS 8'hff
`define VALID_CONV_FLAGS    8'hd0

`define BIT_ADC_DONE        7
`define BIT_WATCHDOG        0

`define RESET_FLAGS         8'h00
`define RESET_MASKS         8'h00
`define UNMAPPED_READ       8'h00

`endif

// File: shared/charger_event_pkg.sv
// types shared by the charger event flag and mask bank
`default_nettype none

package charger_event_pkg;

  typedef logic [7:0] byte_t;

  // one-hot register select, index order matches the flag array
  typedef logic [4:0] reg_sel_t;

  localparam int NumFlagRegs = 4;
  localparam int SelMask     = 4;

endpackage

`default_nettype wire

// File: testbench/host_model.sv
// host side model issuing single-byte register accesses
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic       core_clk,
  output var  logic [7:0] regAddr,
  output var  logic       regWrEn,
  output var  logic [7:0] regWrData,
  output var  logic       regRdEn
);
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end

  // one strobe cycle, then address and data are released inverted so
  // nothing downstream can lean on stale bus values
  task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge core_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = w;
    regRdEn = !w;
    @(negedge core_clk);
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
  endtask
endmodule

`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench of the charger event flag and mask bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import charger_event_pkg::*;
  logic core_clk, reset_n, regResetCmd, adcOneShot, irqOut, regWrEn, regRdEn, rdPend;
  logic [7:0] regAddr;
  byte_t regWrData, regRdData, busS, inS, thS, cvS, batF, b;
  logic [31:0] laterMasks, seed, r;
  byte_t exp[$];
  int numErrors, comparisons;

  host_model host (.core_clk, .regAddr, .regWrEn, .regWrData, .regRdEn);

  charger_event_flag_mask_bank dut (.core_clk, .reset_n, .regAddr, .regWrEn, .regWrData,
    .regRdEn, .regRdData, .regResetCmd, .busCurrentStatus(busS), .inputStatus(inS),
    .thermalStatus(thS), .converterStatus(cvS), .adcOneShot, .batteryFlags(batF),
    .laterMasks, .irqOut);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string n, input byte_t e, input byte_t s);
    comparisons++;
    if (s !== e) begin
      numErrors++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rd(input logic [7:0] a, input byte_t e);
    exp.push_back(e);
    host.acc(a, 8'h00, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input byte_t d);
    host.acc(a, d, 1'b1);
  endtask

  // irq settles two edges after its cause, three falling edges is safe
  task automatic irq(input logic e);
    repeat (3) @(negedge core_clk);
    chk("irqOut", {7'h00, e}, {7'h00, irqOut});
  endtask

  task automatic reportAndStop();
    $display("errors %0d comparisons %0d", numErrors, comparisons);
    if (numErrors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // read data answers exactly one edge after the strobe
  always @(posedge core_clk) rdPend <= regRdEn;
  always @(negedge core_clk) if (rdPend === 1'b1) chk("regRdData", exp.pop_front(), regRdData);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    #20000;
    numErrors++;
    reportAndStop();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    reset_n = 0; regResetCmd = 0; adcOneShot = 0; laterMasks = '1;
    busS = 0; inS = 0; thS = 0; cvS = 0; batF = 0; seed = 32'hb5500eb4;
    repeat (8) @(negedge core_clk);
    reset_n = 1;
    repeat (3) @(negedge core_clk);
    for (int a = 8'h19; a <= 8'h1d; a++) rd(8'(a), 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h19, 8'hff);
    rd(8'h19, 8'h00);
    r = rnd();
    wr(8'h1d, r[7:0]);
    rd(8'h1d, r[7:0]);
    for (int i = 0; i < 8; i++) begin
      b = 8'h01 << i;
      batF = b;
      wr(8'h1d, ~b);
      irq(1'b1);
      wr(8'h1d, b);
      irq(1'b0);
    end
    // every bank bit blocked at once
    wr(8'h1d, 8'hff);
    irq(1'b0);
    regResetCmd = 1;
    @(negedge core_clk);
    regResetCmd = 0;
    irq(1'b1);
    rd(8'h1d, 8'h00);
    batF = 0;
    irq(1'b0);
    busS = 8'hff;
    rd(8'h19, 8'hf4);
    rd(8'h19, 8'h00);
    r = rnd();
    inS = r[7:0];
    rd(8'h1a, r[7:0]);
    thS = 8'hff;
    rd(8'h1b, 8'h7f);
    adcOneShot = 1;
    thS = 8'h7f;
    rd(8'h1b, 8'h80);
    thS = 8'h7e;
    rd(8'h1b, 8'h01);
    // die alarm changes on the very edge that takes the read: the set must win
    fork
      rd(8'h1b, 8'h00);
      begin
        @(negedge core_clk);
        thS = 8'h7c;
      end
    join
    rd(8'h1b, 8'h02);
    cvS = 8'hff;
    rd(8'h1c, 8'hd0);
    laterMasks = 32'hffffefff;
    inS = inS ^ 8'h10;
    irq(1'b1);
    rd(8'h1a, 8'h10);
    irq(1'b0);
    reportAndStop();
  end
endmodule

`default_nettype wire
